// File: src/pllsc_core.sv
// synthesizer core: dividers, phase detector, lock and pin routing
`timescale 1ns/1ps
module pllsc_core
    import pllsc_pkg::*;
(
    input  wire logic  ref_clk_in,
    input  wire logic  rstn_in,
    input  wire logic  ser_clk_in,
    input  wire logic  ser_data_in,
    input  wire logic  strobe_in,
    input  wire logic  run_standby_in,
    input  wire logic  reference_osc_input_in,
    input  wire logic  prescaler_count_input_in,
    input  wire logic  external_ref_in,
    input  wire logic  band_two_or_ext_cmp_in,
    output logic       band_two_or_ext_cmp_out,
    output logic       band_two_or_ext_cmp_oe_out,
    output logic       band_one_or_cmp_out,
    output logic       prescaler_ratio_select_out,
    output logic       charge_pump_out,
    output logic       charge_pump_oe_out,
    output logic       raise_n_out,
    output logic       lower_n_out,
    output logic       lock_out,
    output logic       divided_ref_out,
    output logic       ref_buffer_out_a,
    output logic       ref_buffer_out_b
);
    logic [WORD_W-1:0]    word_one;
    logic [WORD_W-1:0]    word_two;
    pllsc_mode_t          mode_ff;
    logic                 run;
    logic                 ref_phase_signal;
    logic                 int_ref_evt;
    logic                 ext_ref_prev_ff;
    logic                 ext_cmp_prev_ff;
    logic                 pc_prev_ff;
    logic                 pc_evt;
    logic [W2_SWAL_W-1:0] swal_cnt_ff;
    logic [W2_MAIN_W-1:0] main_cnt_ff;
    logic [W2_SWAL_W-1:0] swal_load;
    logic [W2_MAIN_W-1:0] main_load;
    logic                 int_cmp_evt_ff;
    logic                 cmp_phase_signal_ff;
    logic                 ref_evt;
    logic                 cmp_evt;
    logic                 up_ff;
    logic                 dn_ff;
    logic                 up_set;
    logic                 dn_set;
    logic                 pfd_clear;
    logic [7:0]           err_cnt_ff;
    logic                 locked_ff;
    logic                 sense;

    pllsc_serial_port u_serial (
        .ref_clk_in   (ref_clk_in),
        .rstn_in      (rstn_in),
        .ser_clk_in   (ser_clk_in),
        .ser_data_in  (ser_data_in),
        .strobe_in    (strobe_in),
        .word_one_out (word_one),
        .word_two_out (word_two)
    );

    pllsc_ref_divider #(
        .CNT_W (W1_N_W)
    ) u_ref_div (
        .ref_clk_in    (ref_clk_in),
        .rstn_in       (rstn_in),
        .run_in        (run),
        .osc_in        (reference_osc_input_in),
        .div_two_in    (word_one[W1_DIV_SEL]),
        .n_in          (word_one[W1_N_LSB +: W1_N_W]),
        .ref_phase_out (ref_phase_signal),
        .ref_evt_out   (int_ref_evt)
    );

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode_ff <= PLLSC_STANDBY;
        end else begin
            unique case (run_standby_in)
                1'b0: mode_ff <= PLLSC_RUN;
                1'b1: mode_ff <= PLLSC_STANDBY;
            endcase
        end
    end

    assign run   = (mode_ff == PLLSC_RUN) && !run_standby_in;
    assign sense = word_one[W1_SENSE];

    // input edge history
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ext_ref_prev_ff <= 1'b0;
            ext_cmp_prev_ff <= 1'b0;
            pc_prev_ff      <= 1'b0;
        end else begin
            ext_ref_prev_ff <= external_ref_in;
            ext_cmp_prev_ff <= band_two_or_ext_cmp_in;
            pc_prev_ff      <= prescaler_count_input_in;
        end
    end

    assign pc_evt = word_one[W1_PC_EDGE] ? (prescaler_count_input_in && !pc_prev_ff)
                                         : (!prescaler_count_input_in && pc_prev_ff);

    // ratio split: swallow low bits, main high bits
    assign swal_load = word_two[W2_SWAL_LSB +: W2_SWAL_W];
    assign main_load = word_two[W2_MAIN_LSB +: W2_MAIN_W];

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            swal_cnt_ff    <= '0;
            main_cnt_ff    <= '0;
            int_cmp_evt_ff <= 1'b0;
        end else if (!run) begin
            swal_cnt_ff    <= swal_load;
            main_cnt_ff    <= main_load;
            int_cmp_evt_ff <= 1'b0;
        end else begin
            int_cmp_evt_ff <= 1'b0;
            if (pc_evt) begin
                if (main_cnt_ff <= 10'h001) begin
                    swal_cnt_ff    <= swal_load;
                    main_cnt_ff    <= main_load;
                    int_cmp_evt_ff <= 1'b1;
                end else begin
                    main_cnt_ff <= main_cnt_ff - 1'b1;
                    if (swal_cnt_ff != '0) begin
                        swal_cnt_ff <= swal_cnt_ff - 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prescaler_ratio_select_out <= 1'b0;
        end else begin
            prescaler_ratio_select_out <= run && !run_standby_in && (swal_cnt_ff != '0);
        end
    end

    // comparison phase signal halves the comparison events
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cmp_phase_signal_ff <= 1'b0;
        end else if (!run) begin
            cmp_phase_signal_ff <= 1'b0;
        end else if (int_cmp_evt_ff) begin
            cmp_phase_signal_ff <= !cmp_phase_signal_ff;
        end
    end

    assign ref_evt = run && (word_one[W1_EXT_REF] ? (external_ref_in && !ext_ref_prev_ff)
                                                  : int_ref_evt);
    assign cmp_evt = run && (word_one[W1_EXT_CMP]
                             ? (band_two_or_ext_cmp_in && !ext_cmp_prev_ff)
                             : int_cmp_evt_ff);

    assign up_set    = up_ff || ref_evt;
    assign dn_set    = dn_ff || cmp_evt;
    assign pfd_clear = up_set && dn_set;

    // phase frequency detector
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            up_ff <= 1'b0;
            dn_ff <= 1'b0;
        end else if (!run || pfd_clear) begin
            up_ff <= 1'b0;
            dn_ff <= 1'b0;
        end else begin
            up_ff <= up_set;
            dn_ff <= dn_set;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            charge_pump_out    <= 1'b0;
            charge_pump_oe_out <= 1'b0;
        end else begin
            charge_pump_oe_out <= up_ff ^ dn_ff;
            charge_pump_out    <= up_ff ^ sense;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            raise_n_out <= 1'b1;
            lower_n_out <= 1'b1;
        end else begin
            raise_n_out <= !(sense ? (dn_ff && !up_ff) : (up_ff && !dn_ff));
            lower_n_out <= !(sense ? (up_ff && !dn_ff) : (dn_ff && !up_ff));
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            err_cnt_ff <= '0;
            locked_ff  <= 1'b0;
            lock_out   <= 1'b0;
        end else if (!run) begin
            err_cnt_ff <= '0;
            locked_ff  <= 1'b0;
            lock_out   <= 1'b0;
        end else begin
            if (pfd_clear) begin
                err_cnt_ff <= '0;
                locked_ff  <= (err_cnt_ff <= LOCK_WIN_CYC);
            end else if ((up_ff || dn_ff) && err_cnt_ff != 8'hff) begin
                err_cnt_ff <= err_cnt_ff + 1'b1;
            end
            if (word_one[W1_LOCK_MODE]) begin
                lock_out <= pfd_clear && (err_cnt_ff <= LOCK_WIN_CYC);
            end else begin
                lock_out <= locked_ff;
            end
        end
    end

    // pin routing
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            band_two_or_ext_cmp_out    <= 1'b0;
            band_two_or_ext_cmp_oe_out <= 1'b0;
            band_one_or_cmp_out        <= 1'b0;
            divided_ref_out            <= 1'b0;
            ref_buffer_out_a           <= 1'b0;
            ref_buffer_out_b           <= 1'b0;
        end else begin
            band_two_or_ext_cmp_oe_out <= !word_one[W1_EXT_CMP];
            band_two_or_ext_cmp_out    <= word_two[W2_BAND_TWO];
            band_one_or_cmp_out        <= word_one[W1_CMP_OUT] ? cmp_phase_signal_ff
                                                               : word_two[W2_BAND_ONE];
            divided_ref_out            <= word_one[W1_REF_OUT] && ref_phase_signal;
            ref_buffer_out_a           <= !word_one[W1_BUF_GATE] && reference_osc_input_in;
            ref_buffer_out_b           <= !word_one[W1_BUF_GATE] && reference_osc_input_in;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_swallowing;
        run && !run_standby_in && swal_cnt_ff != '0;
    endsequence

    sequence s_main_only;
        run && !run_standby_in && swal_cnt_ff == '0;
    endsequence

    a_ratio_standby: assert property (run_standby_in |=> !prescaler_ratio_select_out)
        else $error("ratio select not low in standby");
    a_ratio_swallow: assert property (s_swallowing
        ##0 (pc_evt && main_cnt_ff > 10'h001) |=> swal_cnt_ff == $past(swal_cnt_ff) - 7'h01)
        else $error("swallow count did not step");
    a_ratio_main: assert property (s_main_only
        ##0 (pc_evt && main_cnt_ff <= 10'h001) |=> swal_cnt_ff == $past(swal_load))
        else $error("swallow count not reloaded");
    a_count_rise: assert property (run && word_one[W1_PC_EDGE]
        && $rose(prescaler_count_input_in) && main_cnt_ff > 10'h001
        |=> main_cnt_ff == $past(main_cnt_ff) - 10'h001)
        else $error("main count missed rising edge");
    a_count_fall: assert property (run && !word_one[W1_PC_EDGE]
        && $fell(prescaler_count_input_in) && main_cnt_ff > 10'h001
        |=> main_cnt_ff == $past(main_cnt_ff) - 10'h001)
        else $error("main count missed falling edge");
    a_count_idle: assert property (run && word_one[W1_PC_EDGE]
        && $fell(prescaler_count_input_in) |=> $stable(main_cnt_ff))
        else $error("main count moved on unselected edge");
    a_standby_hold: assert property (run_standby_in
        |=> main_cnt_ff == $past(main_load) && !up_ff && !dn_ff)
        else $error("dividers not held in standby");
    a_pump_float: assert property (up_ff == dn_ff |=> !charge_pump_oe_out)
        else $error("charge pump driven when in phase");
    a_pump_lead: assert property (up_ff && !dn_ff
        |=> charge_pump_oe_out && charge_pump_out == !$past(sense))
        else $error("charge pump level wrong on lead");
    a_pump_lag: assert property (dn_ff && !up_ff
        |=> charge_pump_oe_out && charge_pump_out == $past(sense))
        else $error("charge pump level wrong on lag");
    // raise on lead or lag by sense
    a_raise_lead: assert property (!sense && up_ff && !dn_ff
        |=> !raise_n_out && lower_n_out)
        else $error("raise output wrong on lead");
    a_raise_lag: assert property (sense && dn_ff && !up_ff
        |=> !raise_n_out && lower_n_out)
        else $error("raise output wrong on lag");
    // lower on lead with sense one
    a_lower_lead: assert property (sense && up_ff && !dn_ff
        |=> !lower_n_out && raise_n_out)
        else $error("lower output wrong on lead");
    a_ref_gate: assert property (!word_one[W1_REF_OUT] |=> !divided_ref_out)
        else $error("divided reference leaked");
    a_buffer_gate: assert property (word_one[W1_BUF_GATE]
        |=> !ref_buffer_out_a && !ref_buffer_out_b)
        else $error("reference buffer not held low");
    a_buffer_pass: assert property (!word_one[W1_BUF_GATE]
        |=> ref_buffer_out_a == $past(reference_osc_input_in)
        && ref_buffer_out_b == $past(reference_osc_input_in))
        else $error("reference buffer not passing oscillator");
    a_band_route: assert property (!word_one[W1_CMP_OUT] && !word_one[W1_EXT_CMP]
        |=> band_one_or_cmp_out == $past(word_two[W2_BAND_ONE])
        && band_two_or_ext_cmp_oe_out)
        else $error("band bits not on shared pins");
    a_pin_input: assert property (word_one[W1_EXT_CMP] |=> !band_two_or_ext_cmp_oe_out)
        else $error("shared pin driven in input mode");
    // lock clears in standby, pulses only at comparison
    a_lock_standby: assert property (run_standby_in |=> !lock_out)
        else $error("lock shown in standby");
    a_lock_pulse: assert property (word_one[W1_LOCK_MODE] && !pfd_clear |=> !lock_out)
        else $error("lock pulse outside comparison");
endmodule : pllsc_core

// File: src/pllsc_pkg.sv
// constants and field layout for the synthesizer serial control core
// Function
// - two 24-bit control words are filled from serial data and steer the core
// - the last bit of a frame picks the word: one to word one, zero to two
// - the shifted frame moves into the chosen word only while strobe is high
// - programming bits are captured only on the serial clock
// - standby input low runs the dividers, high holds them in standby
// - prescaler ratio select is forced low while standby input is high
// - reference phase comes from an 11-bit counter and a divide-by-two stage
// - divide-select zero divides reference by 2N, one divides by two
// - comparison divider uses 10-bit main and 7-bit swallow counters
// - word two holds the 17-bit total comparison ratio for 128/129 prescaler
// - charge pump drives high, floats or low by phase, inverted by sense bit
// - raise output goes low on lead when sense bit is zero, or on lag when sense bit is one
// - bit 20 takes the phase reference from the external reference pin
// - bit 19 gates the divided reference onto its output pin
// - bit 18 takes the comparison input from the shared pin as input
// - bit 12 high holds both reference buffer outputs low
// - lock output high while locked, bit 22 picks level or pulse
// - bit 16 picks rising or falling prescaler edge for counting
package pllsc_pkg;
    localparam int unsigned WORD_W       = 24;
    localparam logic [23:0] WORD_RST     = 24'h00_0000;
    localparam int unsigned SEL_BIT      = 23;
    // word one fields
    localparam int unsigned W1_DIV_SEL   = 0;
    localparam int unsigned W1_N_LSB     = 1;
    localparam int unsigned W1_N_W       = 11;
    localparam int unsigned W1_BUF_GATE  = 12;
    localparam int unsigned W1_PC_EDGE   = 16;
    localparam int unsigned W1_CMP_OUT   = 17;
    localparam int unsigned W1_EXT_CMP   = 18;
    localparam int unsigned W1_REF_OUT   = 19;
    localparam int unsigned W1_EXT_REF   = 20;
    localparam int unsigned W1_SENSE     = 21;
    localparam int unsigned W1_LOCK_MODE = 22;
    // word two fields
    localparam int unsigned W2_SWAL_LSB  = 0;
    localparam int unsigned W2_SWAL_W    = 7;
    localparam int unsigned W2_MAIN_LSB  = 7;
    localparam int unsigned W2_MAIN_W    = 10;
    localparam int unsigned W2_BAND_ONE  = 18;
    localparam int unsigned W2_BAND_TWO  = 19;
    // lock window in reference clock cycles of phase error
    localparam logic [7:0]  LOCK_WIN_CYC = 8'h04;
    typedef enum logic [0:0] {
        PLLSC_RUN     = 1'b0,
        PLLSC_STANDBY = 1'b1
    } pllsc_mode_t;
endpackage : pllsc_pkg

// File: src/pllsc_serial_port.sv
// three-wire serial port filling the two control words
`timescale 1ns/1ps
module pllsc_serial_port
    import pllsc_pkg::*;
(
    input  wire logic              ref_clk_in,
    input  wire logic              rstn_in,
    input  wire logic              ser_clk_in,
    input  wire logic              ser_data_in,
    input  wire logic              strobe_in,
    output logic [WORD_W-1:0]      word_one_out,
    output logic [WORD_W-1:0]      word_two_out
);
    logic              sclk_prev_ff;
    logic [WORD_W-1:0] shift_ff;

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sclk_prev_ff <= 1'b0;
            shift_ff     <= WORD_RST;
        end else begin
            sclk_prev_ff <= ser_clk_in;
            if (ser_clk_in && !sclk_prev_ff) begin
                shift_ff <= {ser_data_in, shift_ff[WORD_W-1:1]};
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            word_one_out <= WORD_RST;
            word_two_out <= WORD_RST;
        end else if (strobe_in) begin
            if (shift_ff[SEL_BIT]) begin
                word_one_out <= shift_ff;
            end else begin
                word_two_out <= shift_ff;
            end
        end
    end

    a_hold_no_strobe: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        !strobe_in |=> $stable(word_one_out) && $stable(word_two_out))
        else $error("control word changed without strobe");
    a_word_select: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        strobe_in && !shift_ff[SEL_BIT] |=> word_two_out == $past(shift_ff)
            && $stable(word_one_out))
        else $error("frame went to wrong word");
    a_word_one_sel: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        strobe_in && shift_ff[SEL_BIT] |=> word_one_out == $past(shift_ff)
            && $stable(word_two_out))
        else $error("frame missed word one");
endmodule : pllsc_serial_port

// File: src/pllsc_ref_divider.sv
// reference divider: 11-bit counter then divide by two
`timescale 1ns/1ps
module pllsc_ref_divider
    import pllsc_pkg::*;
#(
    parameter int unsigned CNT_W = W1_N_W
)
(
    input  wire logic              ref_clk_in,
    input  wire logic              rstn_in,
    input  wire logic              run_in,
    input  wire logic              osc_in,
    input  wire logic              div_two_in,
    input  wire logic [CNT_W-1:0]  n_in,
    output logic                   ref_phase_out,
    output logic                   ref_evt_out
);
    if (CNT_W < 2 || CNT_W > 16) begin : g_bad_cnt_w
        $error("CNT_W out of range");
    end

    logic             osc_prev_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic             osc_rise;
    logic             tick;

    assign osc_rise = osc_in && !osc_prev_ff;
    // N counts, zero treated as one
    assign tick     = osc_rise && (div_two_in || (cnt_ff + 1'b1 >= n_in));

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            osc_prev_ff   <= 1'b0;
            cnt_ff        <= '0;
            ref_phase_out <= 1'b0;
            ref_evt_out   <= 1'b0;
        end else begin
            osc_prev_ff <= osc_in;
            ref_evt_out <= run_in && tick && !ref_phase_out;
            if (!run_in) begin
                cnt_ff        <= '0;
                ref_phase_out <= 1'b0;
            end else if (tick) begin
                cnt_ff        <= '0;
                ref_phase_out <= !ref_phase_out;
            end else if (osc_rise) begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end
endmodule : pllsc_ref_divider

// File: verification/pllsc_host_model.sv
// host model driving the three-wire serial programming port
`timescale 1ns/1ps
module pllsc_host_model (
    input  wire logic ref_clk_in,
    output logic      ser_clk_out,
    output logic      ser_data_out,
    output logic      strobe_out
);
    // lines rest at their pull-down level
    initial begin
        ser_clk_out = 1'b0;
        ser_data_out = 1'b0;
        strobe_out = 1'b0;
    end
    task automatic send(input bit [23:0] w, input bit ld);
        for (int i = 0; i < 24; i++) begin
            @(posedge ref_clk_in) #1;
            ser_data_out = w[i];
            @(posedge ref_clk_in) #1;
            ser_clk_out = 1'b1;
            @(posedge ref_clk_in) #1;
            ser_clk_out = 1'b0;
        end
        @(posedge ref_clk_in) #1;
        ser_data_out = 1'b0;
        strobe_out = ld;
        @(posedge ref_clk_in) #1;
        strobe_out = 1'b0;
        @(posedge ref_clk_in) #1;
    endtask : send
endmodule : pllsc_host_model

// File: verification/pllsc_core_tb_top.sv
// self-checking bench for the synthesizer serial control core
`timescale 1ns/1ps
module pllsc_core_tb_top;
    import pllsc_pkg::*;
    logic ref_clk_in = 1'b0, rstn_in = 1'b0, run_standby_in = 1'b1, ext_cmp_drv = 1'b0;
    logic reference_osc_input_in = 1'b0, prescaler_count_input_in = 1'b0, external_ref_in = 1'b0;
    logic ser_clk_in, ser_data_in, strobe_in, band_two_or_ext_cmp_in, band_two_or_ext_cmp_out;
    logic band_two_or_ext_cmp_oe_out, band_one_or_cmp_out, prescaler_ratio_select_out;
    logic charge_pump_out, charge_pump_oe_out, raise_n_out, lower_n_out, lock_out;
    logic divided_ref_out, ref_buffer_out_a, ref_buffer_out_b;
    logic [7:0] tick = 8'h00, lag = 8'h00, dly;
    bit [23:0] m_w1, m_w2;
    bit [31:0] seed = 32'h12ae_3c1c;
    int miscompares = 0, cmp_count = 0, n_hi, n_lo, n_up, n_dn, n_rise, n_p1, n_p0, n_lk;

    assign band_two_or_ext_cmp_in = band_two_or_ext_cmp_oe_out ? band_two_or_ext_cmp_out
                                                               : ext_cmp_drv;
    pllsc_host_model u_pllsc_host_model (.ref_clk_in, .ser_clk_out(ser_clk_in),
        .ser_data_out(ser_data_in), .strobe_out(strobe_in));
    pllsc_core u_pllsc_core (.ref_clk_in, .rstn_in, .ser_clk_in, .ser_data_in, .strobe_in,
        .run_standby_in, .reference_osc_input_in, .prescaler_count_input_in, .external_ref_in,
        .band_two_or_ext_cmp_in, .band_two_or_ext_cmp_out, .band_two_or_ext_cmp_oe_out,
        .band_one_or_cmp_out, .prescaler_ratio_select_out, .charge_pump_out,
        .charge_pump_oe_out, .raise_n_out, .lower_n_out, .lock_out, .divided_ref_out,
        .ref_buffer_out_a, .ref_buffer_out_b);

    always #12.5 ref_clk_in = ~ref_clk_in;
    // oscillator, prescaler and external phase sources
    always @(posedge ref_clk_in) begin
        #1;
        tick = tick + 8'h01;
        dly = tick - lag;
        reference_osc_input_in = ~reference_osc_input_in;
        prescaler_count_input_in = tick[1];
        external_ref_in = tick[3];
        ext_cmp_drv = dly[3];
    end

    function automatic bit [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xorshift
    task automatic chk(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask : chk
    task automatic print_verdict();
        if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
        #2;
    endtask : cyc
    task automatic load(input bit [23:0] w, input bit ld);
        u_pllsc_host_model.send(w, ld);
        if (ld && w[SEL_BIT]) m_w1 = w;
        else if (ld) m_w2 = w;
        cyc(1);
    endtask : load
    // tallies output activity over n cycles
    task automatic watch(input int n);
        logic prev;
        {n_hi, n_lo, n_up, n_dn, n_rise, n_p1, n_p0, n_lk} = '0;
        prev = divided_ref_out;
        repeat (n) begin
            cyc(1);
            if (prescaler_ratio_select_out === 1'b1) n_hi++;
            if (prescaler_ratio_select_out === 1'b0) n_lo++;
            if (raise_n_out === 1'b0) n_up++;
            if (lower_n_out === 1'b0) n_dn++;
            if (divided_ref_out === 1'b1 && prev === 1'b0) n_rise++;
            if (charge_pump_oe_out === 1'b1 && charge_pump_out === 1'b1) n_p1++;
            if (charge_pump_oe_out === 1'b1 && charge_pump_out === 1'b0) n_p0++;
            if (lock_out === 1'b1) n_lk++;
            prev = divided_ref_out;
        end
    endtask : watch

    initial begin
        #500000;
        miscompares++;
        print_verdict();
    end

    initial begin
        bit [23:0] w;
        bit [31:0] r;
        int ex;
        bit match;
        cyc(6);
        chk(raise_n_out, 1'b1, "raise idle");
        chk(lower_n_out, 1'b1, "lower idle");
        chk(lock_out, 1'b0, "lock idle");
        rstn_in = 1'b1;
        cyc(1);
        load(24'h80_0000, 1'b1);
        repeat (4) begin
            r = xorshift();
            w = {4'h0, r[19:18], 1'b0, r[16:0]};
            for (int ld = 1; ld >= 0; ld--) begin
                load(ld ? w : w ^ 24'h0c_0000, ld[0]);
                chk(band_one_or_cmp_out, m_w2[W2_BAND_ONE], "band one");
                chk(band_two_or_ext_cmp_out, m_w2[W2_BAND_TWO], "band two");
                chk(band_two_or_ext_cmp_oe_out, 1'b1, "pin drive");
            end
        end
        repeat (4) begin
            cyc(1);
            chk(ref_buffer_out_a, ~reference_osc_input_in, "buffer a");
            chk(ref_buffer_out_b, ~reference_osc_input_in, "buffer b");
        end
        load(24'h80_1000, 1'b1);
        cyc(2);
        chk(ref_buffer_out_a | ref_buffer_out_b, 1'b0, "buffer held");
        run_standby_in = 1'b0;
        for (int d = 0; d < 3; d++) begin
            load(d == 2 ? 24'h80_0006 : 24'h88_0006 | 24'(d), 1'b1);
            watch(240);
            ex = d == 2 ? 0 : (d == 1 ? 60 : 20);
            chk(n_rise >= ex - 1 && n_rise <= ex + 1, 1'b1, "ref rate");
        end
        run_standby_in = 1'b1;
        load(24'h81_0000, 1'b1);
        load(24'h00_0283, 1'b1);
        watch(60);
        chk(n_hi == 0, 1'b1, "ratio standby");
        run_standby_in = 1'b0;
        watch(200);
        chk(n_hi >= 116 && n_hi <= 124 && n_lo > 0, 1'b1, "ratio cycle");
        load(24'h94_0000, 1'b1);
        cyc(300);
        chk(lock_out, 1'b1, "lock level");
        chk(band_two_or_ext_cmp_oe_out, 1'b0, "pin input");
        chk(raise_n_out & lower_n_out, 1'b1, "equal phase");
        load(24'hd4_0000, 1'b1);
        watch(320);
        chk(n_lk >= 19 && n_lk <= 21, 1'b1, "lock pulse");
        for (int s = 0; s < 4; s++) begin
            lag = s[1] ? 8'hfe : 8'h02;
            match = s[0] == s[1];
            load(24'h94_0000 | (24'(s[0]) << W1_SENSE), 1'b1);
            watch(320);
            chk(match ? n_up > 0 && n_dn == 0 : n_dn > 0 && n_up == 0, 1'b1, "lead");
            chk(match ? n_p1 > 0 && n_p0 == 0 : n_p0 > 0 && n_p1 == 0, 1'b1, "pump");
        end
        print_verdict();
    end
endmodule : pllsc_core_tb_top
